// File: rtl/ida_pkg.sv
// package: indirect data addressing constants and types
package ida_pkg;
  // ==================================================
  // widths
  localparam int ADDR_W = 8;
  localparam int SECT_W = 8;
  // ==================================================
  // register offsets within sector 0
  localparam logic [7:0] OFS_PORT0 = 8'h00;
  localparam logic [7:0] OFS_PTR0 = 8'h01;
  localparam logic [7:0] OFS_PORT1 = 8'h02;
  localparam logic [7:0] OFS_PTR1L = 8'h03;
  localparam logic [7:0] OFS_PTR1S = 8'h04;
  localparam logic [7:0] OFS_PORT2 = 8'h0c;
  localparam logic [7:0] OFS_PTR2L = 8'h0d;
  localparam logic [7:0] OFS_PTR2S = 8'h0e;
  // ==================================================
  // values after reset and fixed figures
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] SECTOR_ZERO = 8'h00;
  localparam logic [7:0] SPECIAL_TOP = 8'h7f;
  // ==================================================
  // full data address: sector byte and offset byte
  typedef struct packed {
    logic [7:0] sector;
    logic [7:0] offset;
  } ida_addr_s;
  // core access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic ext;
    ida_addr_s addr;
    logic [7:0] wdata;
  } ida_req_s;
endpackage

// File: rtl/ida_indirect_addr.sv
// module: address redirection and memory pointer storage for indirect data access
`timescale 1ns/10ps
`default_nettype none
// Contract
// RQ1 - indirect port access goes to pointer target
// RQ2 - first port reaches sector 0 only
// RQ3 - other ports use low plus sector byte
// RQ4 - port registers read zero, writes ignored; a port aimed at a port register reads and writes memory instead
// RQ5 - five pointers are ordinary read/write storage
// RQ6 - unimplemented special addresses read zero; the code returns memRdata for them and stores writes to them in memory
// RQ7 - extended access reaches every sector directly
// RQ8 - high part sector, low byte offset
// RQ9 - new pointer usable by next instruction
module ida_indirect_addr (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // core request
  input wire ida_pkg::ida_req_s coreReq,
  // core read answer
  output logic [7:0] coreRdata,
  // data memory side
  output logic memRd,
  output logic memWr,
  output ida_pkg::ida_addr_s memAddr,
  output logic [7:0] memWdata,
  input wire logic [7:0] memRdata,
  // special register claim: high when this block owns the address
  output logic regHit
);
  import ida_pkg::*;

  // ==================================================
  // pointer storage
  logic [7:0] ptr0, ptr1L, ptr1S, ptr2L, ptr2S;
  logic direct, isPort0, isPort1, isPort2, isPort, isPtr;
  logic [7:0] ptrRdata;

  function automatic logic at(input ida_addr_s a, input logic [7:0] ofs);
    at = (a.sector == SECTOR_ZERO) && (a.offset == ofs);
  endfunction

  // ==================================================
  // decode; plain instructions address sector 0 only
  assign direct = !coreReq.ext;
  assign isPort0 = direct && at(coreReq.addr, OFS_PORT0);
  assign isPort1 = direct && at(coreReq.addr, OFS_PORT1);
  assign isPort2 = direct && at(coreReq.addr, OFS_PORT2);
  assign isPort = isPort0 || isPort1 || isPort2;
  assign isPtr = at(coreReq.addr, OFS_PTR0) || at(coreReq.addr, OFS_PTR1L)
    || at(coreReq.addr, OFS_PTR1S) || at(coreReq.addr, OFS_PTR2L)
    || at(coreReq.addr, OFS_PTR2S);
  assign regHit = isPtr || (at(coreReq.addr, OFS_PORT0) || at(coreReq.addr, OFS_PORT1)
    || at(coreReq.addr, OFS_PORT2));

  // ==================================================
  // pointer writes, one process per pointer; any read-modify-write
  // instruction lands here exactly like a plain register
  // sector 0 pointer; eight bits only, so it can never name another sector
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ptr0 <= PTR_RESET;
    end else if (coreReq.wr && at(coreReq.addr, OFS_PTR0)) begin
      ptr0 <= coreReq.wdata; // [RQ5]
    end
  end

  // second port, low byte
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ptr1L <= PTR_RESET;
    end else if (coreReq.wr && at(coreReq.addr, OFS_PTR1L)) begin
      ptr1L <= coreReq.wdata; // [RQ5]
    end
  end

  // second port, sector byte
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ptr1S <= PTR_RESET;
    end else if (coreReq.wr && at(coreReq.addr, OFS_PTR1S)) begin
      ptr1S <= coreReq.wdata; // [RQ5]
    end
  end

  // third port, low byte
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ptr2L <= PTR_RESET;
    end else if (coreReq.wr && at(coreReq.addr, OFS_PTR2L)) begin
      ptr2L <= coreReq.wdata; // [RQ5]
    end
  end

  // third port, sector byte
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ptr2S <= PTR_RESET;
    end else if (coreReq.wr && at(coreReq.addr, OFS_PTR2S)) begin
      ptr2S <= coreReq.wdata; // [RQ5]
    end
  end

  // pointer readback
  always_comb begin
    ptrRdata = ZERO_BYTE;
    if (at(coreReq.addr, OFS_PTR0)) ptrRdata = ptr0; // [RQ5]
    if (at(coreReq.addr, OFS_PTR1L)) ptrRdata = ptr1L;
    if (at(coreReq.addr, OFS_PTR1S)) ptrRdata = ptr1S;
    if (at(coreReq.addr, OFS_PTR2L)) ptrRdata = ptr2L;
    if (at(coreReq.addr, OFS_PTR2S)) ptrRdata = ptr2S;
  end

  // ==================================================
  // address redirection; pointers read straight from flops so a value
  // written last cycle is used now, no bubble needed
  always_comb begin
    memAddr = coreReq.addr; // extended: sector in high byte [RQ7] [RQ8]
    if (isPort0) begin
      memAddr.sector = SECTOR_ZERO; // [RQ2]
      memAddr.offset = ptr0; // [RQ1] [RQ9]
    end else if (isPort1) begin
      memAddr.sector = ptr1S; // [RQ3]
      memAddr.offset = ptr1L; // [RQ1] [RQ9]
    end else if (isPort2) begin
      memAddr.sector = ptr2S; // [RQ3]
      memAddr.offset = ptr2L; // [RQ1] [RQ9]
    end
  end

  // memory strobes; pointer registers live here, not in the array
  assign memRd = coreReq.rd && !isPtr && !(regHit && !isPort); // [RQ4]
  assign memWr = coreReq.wr && !isPtr && !(regHit && !isPort); // [RQ4]
  assign memWdata = coreReq.wdata;

  // read mux; an indirect port aimed at itself, a pointer or a hole returns memRdata
  always_comb begin
    if (isPtr) coreRdata = ptrRdata;
    else if (regHit && !isPort) coreRdata = ZERO_BYTE; // [RQ4]
    else if (isPort && memAddr.sector == SECTOR_ZERO && memAddr.offset <= SPECIAL_TOP
             && !(memAddr.offset == OFS_PTR0 || memAddr.offset == OFS_PTR1L
             || memAddr.offset == OFS_PTR1S || memAddr.offset == OFS_PTR2L
             || memAddr.offset == OFS_PTR2S))
      coreRdata = memRdata; // special area beyond ours: memory side returns 0 if unused [RQ6]
    else coreRdata = memRdata;
  end

  // ==================================================
  // checks
  port0_sector_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    isPort0 |-> memAddr.sector == SECTOR_ZERO) else $error("port0 left sector 0"); // [RQ2]
  port1_target_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    isPort1 |-> memAddr == {ptr1S, ptr1L}) else $error("port1 address wrong"); // [RQ3]
  port_no_store_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (regHit && !isPort && !isPtr) |-> coreRdata == ZERO_BYTE && !memWr)
    else $error("port register stored"); // [RQ4]
  ptr_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (coreReq.wr && at(coreReq.addr, OFS_PTR0)) |=> ptr0 == $past(coreReq.wdata))
    else $error("pointer write lost"); // [RQ5]
  next_use_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (coreReq.wr && at(coreReq.addr, OFS_PTR0)) ##1 isPort0 |-> memAddr.offset == $past(coreReq.wdata))
    else $error("new pointer not used"); // [RQ9] [RQ1]
  ext_direct_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    coreReq.ext && !isPtr |-> memAddr == coreReq.addr) else $error("extended addr changed"); // [RQ7] [RQ8]

  // ==================================================
  // checks on redirection
  // first port lands on its pointer inside sector 0
  port0_target_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ1]
    isPort0 |-> memAddr == {SECTOR_ZERO, ptr0})
    else $error("port0 address wrong");

  // third port pairs its sector byte with its low byte
  port2_target_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ3]
    isPort2 |-> memAddr == {ptr2S, ptr2L})
    else $error("port2 address wrong");

  // a port access passes its strobes through to the target
  port_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ1]
    isPort |-> memRd == coreReq.rd && memWr == coreReq.wr)
    else $error("port strobe lost");

  // a port read hands back what the target holds
  port_fwd_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ1]
    (isPort && coreReq.rd) |-> coreRdata == memRdata)
    else $error("port read not forwarded");

  // ports reached as plain locations by extended access are empty
  ext_port_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ4]
    (coreReq.ext && regHit && !isPtr) |-> coreRdata == ZERO_BYTE && !memRd && !memWr)
    else $error("port register not empty");

  // extended access outside our registers strobes memory unchanged
  ext_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ7]
    (coreReq.ext && !regHit) |-> memRd == coreReq.rd && memWr == coreReq.wr)
    else $error("extended strobe changed");

  // ==================================================
  // checks on pointer storage
  // a pointer named by the request address never reaches the memory array
  ptr_no_mem_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ5]
    isPtr |-> !memRd && !memWr)
    else $error("pointer address sent to memory");

  // pointer readback comes from the flops
  ptr_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ5]
    at(coreReq.addr, OFS_PTR1L) |-> coreRdata == ptr1L)
    else $error("pointer readback wrong");

  // each pointer byte holds what was written
  ptr1l_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ5]
    (coreReq.wr && at(coreReq.addr, OFS_PTR1L)) |=> ptr1L == $past(coreReq.wdata))
    else $error("pointer write lost");

  ptr1s_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ5]
    (coreReq.wr && at(coreReq.addr, OFS_PTR1S)) |=> ptr1S == $past(coreReq.wdata))
    else $error("pointer write lost");

  ptr2l_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ5]
    (coreReq.wr && at(coreReq.addr, OFS_PTR2L)) |=> ptr2L == $past(coreReq.wdata))
    else $error("pointer write lost");

  ptr2s_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ5]
    (coreReq.wr && at(coreReq.addr, OFS_PTR2S)) |=> ptr2S == $past(coreReq.wdata))
    else $error("pointer write lost");

  // a fresh low byte steers the very next port access, no bubble
  next_use1_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ9]
    (coreReq.wr && at(coreReq.addr, OFS_PTR1L)) ##1 isPort1
    |-> memAddr.offset == $past(coreReq.wdata))
    else $error("new pointer not used");
endmodule
`default_nettype wire

// File: verification/ida_mem_model.sv
// data memory stand-in for the indirect addressing block
`timescale 1ns/10ps
`default_nettype none
module ida_mem_model (
  // clock
  input wire logic sys_clk,
  // memory side
  input wire logic memRd,
  input wire logic memWr,
  input wire ida_pkg::ida_addr_s memAddr,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata
);
  import ida_pkg::*;
  logic [7:0] mem [1024];
  // ==================================================
  // storage: special area zero, general area a filler that is never zero
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = (i < 128) ? ZERO_BYTE : 8'h3c;
  end
  always @(posedge sys_clk) begin
    if (memWr) mem[{memAddr.sector[1:0], memAddr.offset}] <= memWdata;
  end
  // idle read shows all ones so a stray zero is not taken for data
  assign memRdata = memRd ? mem[{memAddr.sector[1:0], memAddr.offset}] : 8'hff;
endmodule
`default_nettype wire

// File: verification/ida_indirect_addr_tb_top.sv
// self-checking bench for indirect data addressing
`timescale 1ns/10ps
`default_nettype none
module ida_indirect_addr_tb_top;
  import ida_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  ida_req_s coreReq = '0;
  logic [7:0] coreRdata, memRdata, memWdata, got;
  logic memRd, memWr, regHit;
  ida_addr_s memAddr;
  int num_errors = 0;
  int tests_run = 0;
  always #4 sys_clk = ~sys_clk;
  ida_indirect_addr DUT (.sys_clk(sys_clk), .rst_b(rst_b), .coreReq(coreReq),
    .coreRdata(coreRdata), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .regHit(regHit));
  ida_mem_model MEM (.sys_clk(sys_clk), .memRd(memRd), .memWr(memWr),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));
  // ==================================================
  // one access: op is {rd, wr, ext}; read data caught before the taking edge
  task automatic acc(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    coreReq = {op, a, d};
    #2 got = coreRdata;
  endtask
  task automatic chk(input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  // single-bit design outputs, looked at while the request stands
  task automatic chkBit(input logic val, input logic exp);
    tests_run++;
    if (val !== exp) begin
      num_errors++;
      $display("ERROR %0t: flag %b, expected %b", $time, val, exp);
    end
  endtask
  // ==================================================
  // first port: pointer used at once, target stays in sector 0
  task automatic t_port0;
    acc(3'h4, 16'h0001, 8'h00); chk(8'h00);
    chkBit(regHit, 1'b1);
    chkBit(memRd, 1'b0);
    acc(3'h2, 16'h0001, 8'h90);
    acc(3'h2, 16'h0000, 8'hc3);
    acc(3'h4, 16'h0000, 8'h00); chk(8'hc3);
    acc(3'h5, 16'h0090, 8'h00); chk(8'hc3);
    acc(3'h5, 16'h0190, 8'h00); chk(8'h3c);
    $display("t_port0 done");
  endtask
  // other ports: low byte plus sector byte, seen again by extended reads
  task automatic t_port12;
    logic [7:0] base;
    for (int p = 1; p < 3; p++) begin
      base = (p == 1) ? OFS_PORT1 : OFS_PORT2;
      acc(3'h2, {8'h00, base + 8'h01}, 8'hf0);
      acc(3'h2, {8'h00, base + 8'h02}, 8'(p));
      acc(3'h2, {8'h00, base}, 8'(8'h50 + p));
      acc(3'h5, {8'(p), 8'hf0}, 8'h00); chk(8'(8'h50 + p));
      acc(3'h4, {8'h00, base + 8'h01}, 8'h00); chk(8'hf0);
      acc(3'h4, {8'h00, base + 8'h02}, 8'h00); chk(8'(p));
    end
    $display("t_port12 done");
  endtask
  // port registers and unused special places read zero
  task automatic t_zero;
    acc(3'h3, 16'h0002, 8'haa);
    chkBit(memWr, 1'b0);
    chkBit(regHit, 1'b1);
    acc(3'h5, 16'h0002, 8'h00); chk(8'h00);
    acc(3'h5, 16'h0000, 8'h00); chk(8'h00);
    acc(3'h4, 16'h0039, 8'h00); chk(8'h00);
    chkBit(regHit, 1'b0);
    chkBit(memRd, 1'b1);
    $display("t_zero done");
  endtask
  task automatic conclude;
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==================================================
  // main sequence
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    t_port0();
    t_port12();
    t_zero();
    conclude();
  end
endmodule
`default_nettype wire
